// file: pkg/bfm_pkg.sv
/*
 * Constants and types for the bit and flag manipulation unit.
 * Assumes a single core clock and an instruction decoder that presents
 * one operation at a time with its operands.
 */
package bfm_pkg;

    // Operation codes presented by the instruction decoder
    typedef enum logic [4:0] {
        NOP_OP                 = 5'h00,
        IO_BIT_SET_OP          = 5'h01,
        IO_BIT_CLEAR_OP        = 5'h02,
        SHIFT_LEFT_LOGICAL_OP  = 5'h03,
        SHIFT_RIGHT_LOGICAL_OP = 5'h04,
        ROTATE_LEFT_CARRY_OP   = 5'h05,
        ROTATE_RIGHT_CARRY_OP  = 5'h06,
        SHIFT_RIGHT_SIGNED_OP  = 5'h07,
        NIBBLE_SWAP_OP         = 5'h08,
        FLAG_SET_GENERIC_OP    = 5'h09,
        FLAG_CLEAR_GENERIC_OP  = 5'h0A,
        BIT_TO_TRANSFER_OP     = 5'h0B,
        TRANSFER_TO_BIT_OP     = 5'h0C,
        CARRY_SET_OP           = 5'h0D,
        CARRY_CLEAR_OP         = 5'h0E,
        NEGATIVE_SET_OP        = 5'h0F,
        NEGATIVE_CLEAR_OP      = 5'h10,
        ZERO_SET_OP            = 5'h11,
        ZERO_CLEAR_OP          = 5'h12,
        IRQ_ENABLE_OP          = 5'h13,
        IRQ_DISABLE_OP         = 5'h14,
        SIGN_SET_OP            = 5'h15,
        SIGN_CLEAR_OP          = 5'h16,
        OVERFLOW_SET_OP        = 5'h17,
        OVERFLOW_CLEAR_OP      = 5'h18,
        TRANSFER_SET_OP        = 5'h19,
        TRANSFER_CLEAR_OP      = 5'h1A,
        HALF_CARRY_SET_OP      = 5'h1B,
        HALF_CARRY_CLEAR_OP    = 5'h1C,
        SLEEP_OP               = 5'h1D,
        WATCHDOG_RESTART_OP    = 5'h1E,
        BREAK_OP               = 5'h1F
    } bfm_op_t;

    // Status register bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // Register byte offsets on the Avalon slave
    localparam logic [3:0] OFS_STATUS  = 4'h0;
    localparam logic [3:0] OFS_CONTROL = 4'h4;
    localparam logic [3:0] OFS_STATE   = 4'h8;

    // Control register fields
    localparam int CTRL_BREAK_EN = 0;

    // Reset values
    localparam logic [7:0] RST_STATUS  = 8'h00;
    localparam logic [0:0] RST_CONTROL = 1'h0;

endpackage : bfm_pkg

// file: pkg/bfm_alu_if.sv
/*
 * Interface between the control unit and the shift and swap datapath.
 * Assumes both ends sit on the same core clock; the path is combinational.
 */
`timescale 1ns/1ps
interface bfm_alu_if;
    import bfm_pkg::*;

    bfm_op_t    op;
    logic [7:0] operand;
    logic       carry_in;
    logic [7:0] result;
    logic       carry_out;
    logic       zero_out;
    logic       neg_out;
    logic       ovf_out;
    logic       flags_we;

    modport ctrl (output op, operand, carry_in,
                  input  result, carry_out, zero_out, neg_out, ovf_out, flags_we);
    modport alu  (input  op, operand, carry_in,
                  output result, carry_out, zero_out, neg_out, ovf_out, flags_we);
endinterface : bfm_alu_if

// file: logic/bfm_shift.sv
/*
 * Combinational shift, rotate and nibble swap datapath.
 * Assumes the caller registers the result and applies the flags.
 */
`timescale 1ns/1ps
module bfm_shift (
    bfm_alu_if.alu alu
);
    import bfm_pkg::*;

    logic [7:0] res;
    logic       cout;
    logic       upd;

    // Result and carry per operation
    always_comb begin
        res  = alu.operand;
        cout = alu.carry_in;
        upd  = 1'b1;
        case (alu.op)
            SHIFT_LEFT_LOGICAL_OP: begin
                res  = {alu.operand[6:0], 1'b0};
                cout = alu.operand[7];
            end
            SHIFT_RIGHT_LOGICAL_OP: begin
                res  = {1'b0, alu.operand[7:1]};
                cout = alu.operand[0];
            end
            ROTATE_LEFT_CARRY_OP: begin
                res  = {alu.operand[6:0], alu.carry_in};
                cout = alu.operand[7];
            end
            ROTATE_RIGHT_CARRY_OP: begin
                res  = {alu.carry_in, alu.operand[7:1]};
                cout = alu.operand[0];
            end
            SHIFT_RIGHT_SIGNED_OP: begin
                res  = {alu.operand[7], alu.operand[7:1]};
                cout = alu.operand[0];
            end
            NIBBLE_SWAP_OP: begin
                res  = {alu.operand[3:0], alu.operand[7:4]};
                upd  = 1'b0;
            end
            default: begin
                upd  = 1'b0;
            end
        endcase
    end

    // Flags derived from the result
    assign alu.result    = res;
    assign alu.carry_out = cout;
    assign alu.zero_out  = (res == 8'h00);
    assign alu.neg_out   = res[7];
    assign alu.ovf_out   = res[7] ^ cout;
    assign alu.flags_we  = upd;

endmodule : bfm_shift

// file: logic/bfm_top.sv
/*
 * Bit and flag manipulation unit: executes bit set and clear on I/O
 * registers, shifts, rotates, nibble swap, transfer bit moves, status
 * flag set and clear, and the no-op, sleep, watchdog restart and break
 * controls. Status register and control are reachable over Avalon-MM.
 * Assumes the decoder holds an operation until op_ready is seen high,
 * and that the I/O space answers a read in the same cycle as io_re.
 */
//
// Notes on behaviour
// - I/O bit set, no flags, two cycles
// - I/O bit clear, no flags, two cycles
// - Rotate left through carry, flags, one cycle
// - Rotate right through carry, flags, one cycle
// - Signed shift right keeps bit 7; swap nibbles
// - Copy register bit into transfer flag
// - Copy transfer flag into register bit
// - Set overflow flag only, one cycle
// - Clear overflow flag only, one cycle
// - Set sign flag only, one cycle
// - Clear sign flag only, one cycle
// - Set half carry flag only
// - Clear half carry flag only
// - Sleep takes one cycle, signals sleep logic
// - Watchdog restart pulses, one cycle, no flags
// - Break only for debug, no flags
`timescale 1ns/1ps
module bfm_top (
    input  wire logic             clk,
    input  wire logic             rst,
    // Decoder side
    input  wire logic             op_valid,
    input  wire bfm_pkg::bfm_op_t op_code,
    input  wire logic [2:0]       op_bit,
    input  wire logic [4:0]       op_io_addr,
    input  wire logic [7:0]       op_reg_data,
    output logic                  op_ready,
    // Register file write back
    output logic                  rd_we,
    output logic [7:0]            rd_data,
    // I/O space
    output logic                  io_re,
    output logic                  io_we,
    output logic [4:0]            io_addr,
    output logic [7:0]            io_wr_data,
    input  wire logic [7:0]       io_rd_data,
    // Status and control to the rest of the core
    output logic [7:0]            status_register,
    output logic                  sleep_req,
    output logic                  wdt_restart,
    output logic                  break_req,
    // Avalon-MM slave
    input  wire logic [3:0]       avs_address,
    input  wire logic             avs_read,
    input  wire logic             avs_write,
    input  wire logic [31:0]      avs_writedata,
    output logic [31:0]           avs_readdata,
    output logic                  avs_waitrequest
);
    import bfm_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_IO_MOD = 2'b10
    } bfm_state_t;

    bfm_state_t state;
    logic       op_fire;
    logic       io_set;
    logic [2:0] io_bit;
    logic [7:0] next_status_register;
    logic       flag_hit;
    logic [2:0] flag_idx;
    logic       flag_val;
    logic       break_en;
    logic [15:0] retired;
    logic       bus_req;
    logic       bus_ack;
    logic       bus_wr_status;
    logic       bus_wr_ctrl;

    bfm_alu_if alu_bus ();

    bfm_shift u_shift (
        .alu (alu_bus.alu)
    );

    // Feed the shift datapath
    assign alu_bus.op       = op_code;
    assign alu_bus.operand  = op_reg_data;
    assign alu_bus.carry_in = status_register[FLAG_C];

    // Decoder handshake
    assign op_ready = (state == ST_IDLE);
    assign op_fire  = op_valid & op_ready;

    // Status bit addressed by each flag form; generic forms take op_bit
    always_comb begin
        flag_hit = 1'b1;
        flag_idx = op_bit;
        case (op_code)
            CARRY_SET_OP, CARRY_CLEAR_OP:           flag_idx = 3'(FLAG_C);
            NEGATIVE_SET_OP, NEGATIVE_CLEAR_OP:     flag_idx = 3'(FLAG_N);
            ZERO_SET_OP, ZERO_CLEAR_OP:             flag_idx = 3'(FLAG_Z);
            IRQ_ENABLE_OP, IRQ_DISABLE_OP:          flag_idx = 3'(FLAG_I);
            SIGN_SET_OP, SIGN_CLEAR_OP:             flag_idx = 3'(FLAG_S);
            OVERFLOW_SET_OP, OVERFLOW_CLEAR_OP:     flag_idx = 3'(FLAG_V);
            TRANSFER_SET_OP, TRANSFER_CLEAR_OP:     flag_idx = 3'(FLAG_T);
            HALF_CARRY_SET_OP, HALF_CARRY_CLEAR_OP: flag_idx = 3'(FLAG_H);
            FLAG_SET_GENERIC_OP, FLAG_CLEAR_GENERIC_OP: begin
                flag_idx = op_bit;
            end
            default: begin
                flag_hit = 1'b0;
            end
        endcase
    end

    // Set forms write one, clear forms write zero
    always_comb begin
        case (op_code)
            CARRY_SET_OP, NEGATIVE_SET_OP, ZERO_SET_OP, IRQ_ENABLE_OP,
            SIGN_SET_OP, OVERFLOW_SET_OP, TRANSFER_SET_OP, HALF_CARRY_SET_OP,
            FLAG_SET_GENERIC_OP: begin
                flag_val = 1'b1;
            end
            default: begin
                flag_val = 1'b0;
            end
        endcase
    end

    // Next status register value for single cycle operations
    always_comb begin
        next_status_register = status_register;
        if (op_fire) begin
            if (flag_hit) begin
                next_status_register[flag_idx] = flag_val;
            end else if (alu_bus.flags_we) begin
                next_status_register[FLAG_C] = alu_bus.carry_out;
                next_status_register[FLAG_Z] = alu_bus.zero_out;
                next_status_register[FLAG_N] = alu_bus.neg_out;
                next_status_register[FLAG_V] = alu_bus.ovf_out;
            end else if (op_code == BIT_TO_TRANSFER_OP) begin
                next_status_register[FLAG_T] = op_reg_data[op_bit];
            end
        end
    end

    // Status register; a bus write takes precedence over an instruction
    // Software never sees its own write undone by a flag update
    always_ff @(posedge clk) begin
        if (rst) begin
            status_register <= RST_STATUS;
        end else if (bus_wr_status) begin
            status_register <= avs_writedata[7:0];
        end else begin
            status_register <= next_status_register;
        end
    end

    // Sequencer for the two cycle I/O bit operations
    // Holds op_ready low in the read cycle only; the next operation can be taken while io_we is high
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (op_fire && (op_code == IO_BIT_SET_OP ||
                                    op_code == IO_BIT_CLEAR_OP)) begin
                        state <= ST_IO_MOD;
                    end
                end
                ST_IO_MOD: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // I/O read in the first cycle, modified write in the second
    // Other bits go back exactly as read
    always_ff @(posedge clk) begin
        if (rst) begin
            io_re      <= 1'b0;
            io_we      <= 1'b0;
            io_addr    <= 5'h00;
            io_wr_data <= 8'h00;
            io_set     <= 1'b0;
            io_bit     <= 3'h0;
        end else begin
            io_re <= 1'b0;
            io_we <= 1'b0;
            if (op_fire && (op_code == IO_BIT_SET_OP || op_code == IO_BIT_CLEAR_OP)) begin
                io_re   <= 1'b1;
                io_addr <= op_io_addr;
                io_set  <= (op_code == IO_BIT_SET_OP);
                io_bit  <= op_bit;
            end
            if (state == ST_IO_MOD) begin
                io_we      <= 1'b1;
                io_wr_data <= io_rd_data;
                io_wr_data[io_bit] <= io_set;
            end
        end
    end

    // Register file write back for shifts, swap and transfer load
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_we   <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            rd_we <= 1'b0;
            if (op_fire && alu_bus.flags_we) begin
                rd_we   <= 1'b1;
                rd_data <= alu_bus.result;
            end else if (op_fire && op_code == NIBBLE_SWAP_OP) begin
                rd_we   <= 1'b1;
                rd_data <= alu_bus.result;
            end else if (op_fire && op_code == TRANSFER_TO_BIT_OP) begin
                rd_we   <= 1'b1;
                rd_data <= op_reg_data;
                rd_data[op_bit] <= status_register[FLAG_T];
            end
        end
    end

    // Core control pulses; no-op drives nothing
    always_ff @(posedge clk) begin
        if (rst) begin
            sleep_req   <= 1'b0;
            wdt_restart <= 1'b0;
            break_req   <= 1'b0;
        end else begin
            sleep_req   <= op_fire && (op_code == SLEEP_OP);
            wdt_restart <= op_fire && (op_code == WATCHDOG_RESTART_OP);
            break_req   <= op_fire && (op_code == BREAK_OP) && break_en;
        end
    end

    // Count of retired operations, no-op included
    // Wraps silently; software reads it as a progress mark
    always_ff @(posedge clk) begin
        if (rst) begin
            retired <= 16'h0000;
        end else if (op_fire) begin
            retired <= retired + 16'h0001;
        end
    end

    // Avalon slave: one wait cycle, then the answer
    // Registered read data is what costs the wait cycle
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~bus_ack;
    assign bus_wr_status   = avs_write & bus_ack & (avs_address == OFS_STATUS);
    assign bus_wr_ctrl     = avs_write & bus_ack & (avs_address == OFS_CONTROL);

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    // Read data captured in the wait cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !bus_ack) begin
            case (avs_address)
                OFS_STATUS:  avs_readdata <= {24'h000000, status_register};
                OFS_CONTROL: avs_readdata <= {31'h00000000, break_en};
                OFS_STATE:   avs_readdata <= {15'h0000, retired, (state != ST_IDLE)};
                default:     avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // Control register
    always_ff @(posedge clk) begin
        if (rst) begin
            break_en <= RST_CONTROL[0];
        end else if (bus_wr_ctrl) begin
            break_en <= avs_writedata[CTRL_BREAK_EN];
        end
    end

endmodule : bfm_top

// file: tb/bfm_io_space.sv
/*
 * I/O space model on the far side of the bit and flag unit.
 * Assumes read data is sampled in the cycle that io_re is high.
 */
`timescale 1ns/1ps
module bfm_io_space (
    input  wire logic       clk,
    input  wire logic       io_re,
    input  wire logic       io_we,
    input  wire logic [4:0] io_addr,
    input  wire logic [7:0] io_wr_data,
    output logic      [7:0] io_rd_data
);
    logic [7:0] mem [32];
    logic [7:0] last = 8'h00;

    // Known start pattern per address
    initial for (int i = 0; i < 32; i++) mem[i] = 8'h5A ^ 8'(i);

    // Store writes, remember the last byte read
    always @(posedge clk) begin
        if (io_we) mem[io_addr] <= io_wr_data;
        if (io_re) last <= mem[io_addr];
    end

    // Outside a read the bus shows no stale byte
    assign io_rd_data = io_re ? mem[io_addr] : ~last;
endmodule : bfm_io_space

// file: tb/bfm_asserts.sv
/*
 * Timing and flag checks on the bit and flag unit ports.
 * Assumes one clock and the synchronous active-high reset.
 */
`timescale 1ns/1ps
module bfm_asserts
    import bfm_pkg::*;
(
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             op_valid,
    input wire bfm_pkg::bfm_op_t op_code,
    input wire logic [2:0]       op_bit,
    input wire logic [7:0]       op_reg_data,
    input wire logic             op_ready,
    input wire logic             rd_we,
    input wire logic [7:0]       rd_data,
    input wire logic             io_re,
    input wire logic             io_we,
    input wire logic [7:0]       io_wr_data,
    input wire logic [7:0]       io_rd_data,
    input wire logic [7:0]       status_register,
    input wire logic             sleep_req,
    input wire logic             wdt_restart,
    input wire logic             avs_write
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic go;

    // Operation taken with no bus write competing
    assign go = op_valid && op_ready && !avs_write;

    property p_io_set;
        go && op_code == IO_BIT_SET_OP |=> io_re && !op_ready ##1
            io_we && io_wr_data == ($past(io_rd_data) | (8'h01 << $past(op_bit, 2)));
    endproperty
    a_io_set: assert property (p_io_set) else $error("io set wrong");
    property p_io_clr;
        go && op_code == IO_BIT_CLEAR_OP |=> io_re ##1
            io_we && io_wr_data == ($past(io_rd_data) & ~(8'h01 << $past(op_bit, 2)));
    endproperty
    a_io_clr: assert property (p_io_clr) else $error("io clear wrong");
    property p_rol;
        go && op_code == ROTATE_LEFT_CARRY_OP |=> rd_we && status_register[FLAG_C] ==
            $past(op_reg_data[7]) && rd_data == {$past(op_reg_data[6:0]),
            $past(status_register[FLAG_C])};
    endproperty
    a_rol: assert property (p_rol) else $error("rotate left wrong");
    property p_ror;
        go && op_code == ROTATE_RIGHT_CARRY_OP |=> rd_we && status_register[FLAG_C] ==
            $past(op_reg_data[0]) && rd_data == {$past(status_register[FLAG_C]),
            $past(op_reg_data[7:1])};
    endproperty
    a_ror: assert property (p_ror) else $error("rotate right wrong");
    property p_swap;
        go && op_code == NIBBLE_SWAP_OP |=> rd_we && $stable(status_register) &&
            rd_data == {$past(op_reg_data[3:0]), $past(op_reg_data[7:4])};
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong");
    property p_bst;
        go && op_code == BIT_TO_TRANSFER_OP |=> status_register ==
            (($past(status_register) & 8'hBF) | {$past(op_reg_data[op_bit]), 6'h00});
    endproperty
    a_bst: assert property (p_bst) else $error("bit store wrong");
    property p_sev;
        go && op_code == OVERFLOW_SET_OP |=> status_register == ($past(status_register) | 8'h08);
    endproperty
    a_sev: assert property (p_sev) else $error("overflow set wrong");
    property p_cls;
        go && op_code == SIGN_CLEAR_OP |=> status_register == ($past(status_register) & 8'hEF);
    endproperty
    a_cls: assert property (p_cls) else $error("sign clear wrong");
    property p_wdr;
        go && op_code == WATCHDOG_RESTART_OP |=> wdt_restart && $stable(status_register) ##1
            (!wdt_restart || $past(go && op_code == WATCHDOG_RESTART_OP));
    endproperty
    a_wdr: assert property (p_wdr) else $error("restart pulse wrong");
    property p_slp;
        go && op_code == SLEEP_OP |=> sleep_req && op_ready && $stable(status_register);
    endproperty
    a_slp: assert property (p_slp) else $error("sleep wrong");
    property p_nop;
        go && op_code == NOP_OP |=> !rd_we && !io_re && $stable(status_register);
    endproperty
    a_nop: assert property (p_nop) else $error("no-op changed state");

    // Main scenarios reached
    c_io: cover property (go && op_code == IO_BIT_SET_OP);
    c_rol: cover property (go && op_code == ROTATE_LEFT_CARRY_OP);
    c_wdr: cover property (go && op_code == WATCHDOG_RESTART_OP);
endmodule : bfm_asserts

bind bfm_top bfm_asserts chk_u (.clk(clk), .rst(rst), .op_valid(op_valid),
    .op_code(op_code), .op_bit(op_bit), .op_reg_data(op_reg_data), .op_ready(op_ready),
    .rd_we(rd_we), .rd_data(rd_data), .io_re(io_re), .io_we(io_we),
    .io_wr_data(io_wr_data), .io_rd_data(io_rd_data), .status_register(status_register),
    .sleep_req(sleep_req), .wdt_restart(wdt_restart), .avs_write(avs_write));

// file: tb/bit_flag_manipulation_unit_tb_top.sv
/*
 * Self-checking bench for the bit and flag unit.
 * Assumes bfm_io_space answers the I/O reads.
 */
`timescale 1ns/1ps
module bit_flag_manipulation_unit_tb_top;
    import bfm_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, op_valid = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic        op_ready, rd_we, io_re, io_we, sleep_req, wdt_restart, break_req, avs_waitrequest;
    bfm_op_t     op_code = NOP_OP;
    logic [2:0]  op_bit = 3'h0;
    logic [4:0]  op_io_addr = 5'h00;
    logic [4:0]  io_addr;
    logic [7:0]  op_reg_data = 8'h00;
    logic [7:0]  rd_data, io_wr_data, io_rd_data, status_register, es;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rdv;
    int          err_total = 0, checks_done = 0;

    bfm_top dut_u (.clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
        .op_bit(op_bit), .op_io_addr(op_io_addr), .op_reg_data(op_reg_data),
        .op_ready(op_ready), .rd_we(rd_we), .rd_data(rd_data), .io_re(io_re), .io_we(io_we),
        .io_addr(io_addr), .io_wr_data(io_wr_data), .io_rd_data(io_rd_data),
        .status_register(status_register), .sleep_req(sleep_req), .wdt_restart(wdt_restart),
        .break_req(break_req), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    bfm_io_space io_u (.clk(clk), .io_re(io_re), .io_we(io_we), .io_addr(io_addr),
        .io_wr_data(io_wr_data), .io_rd_data(io_rd_data));

    // Clock
    always #5 clk = ~clk;

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tmo();
        err_total++;
        $display("MISMATCH wait expected answer seen timeout");
        complete_run();
    endtask : tmo

    // One Avalon access, held until waitrequest is low
    task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 50) tmo();
        rdv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    // One decoder operation, held until taken; returns with single cycle results settled, before the I/O write
    task automatic op(bfm_op_t c, logic [2:0] b, logic [7:0] d, logic [4:0] a = 5'h05);
        int n;
        @(posedge clk);
        op_code <= c;
        op_bit <= b;
        op_reg_data <= d;
        op_io_addr <= a;
        op_valid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (op_ready === 1'b1) break;
        end
        if (n == 50) tmo();
        op_valid <= 1'b0;
        #1;
    endtask : op

    function automatic logic [8:0] ref_sh(int k, logic [7:0] d, logic c);
        case (k)
            0: return {d[7], d[6:0], 1'b0};
            1: return {d[0], 1'b0, d[7:1]};
            2: return {d[7], d[6:0], c};
            3: return {d[0], c, d[7:1]};
            4: return {d[0], d[7], d[7:1]};
            default: return {c, d[3:0], d[7:4]};
        endcase
    endfunction : ref_sh

    task automatic t_regs();
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("status reset", rdv, {24'h0, RST_STATUS});
        bus(1'b1, OFS_STATUS, 32'h5A);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk("status rw", rdv, 32'h5A);
        bus(1'b1, OFS_CONTROL, 32'h1);
        bus(1'b0, OFS_CONTROL, 32'h0);
        chk("control rw", rdv, 32'h1);
        bus(1'b0, 4'hC, 32'h0);
        chk("unmapped", rdv, 32'h0);
        es = 8'h5A;
    endtask : t_regs

    task automatic t_io();
        op(IO_BIT_SET_OP, 3'h5, 8'h00, 5'h05);
        chk("io read, ready, address", {io_re, op_ready, io_addr}, 7'h45);
        @(posedge clk);
        #1;
        chk("io set data", {io_we, io_wr_data}, 9'h17F);
        op(IO_BIT_CLEAR_OP, 3'h6, 8'h00, 5'h1F);
        @(posedge clk);
        #1;
        chk("io clear data", {io_we, io_wr_data}, 9'h105);
        chk("io flags", status_register, es);
        chk("io stored", io_u.mem[5], 8'h7F);
    endtask : t_io

    task automatic t_shift();
        bfm_op_t so[6] = '{SHIFT_LEFT_LOGICAL_OP, SHIFT_RIGHT_LOGICAL_OP,
            ROTATE_LEFT_CARRY_OP, ROTATE_RIGHT_CARRY_OP, SHIFT_RIGHT_SIGNED_OP, NIBBLE_SWAP_OP};
        logic [7:0] dv[4] = '{8'h81, 8'h80, 8'h01, 8'h6C};
        logic [8:0] r;
        for (int k = 0; k < 6; k++) begin
            for (int j = 0; j < 4; j++) begin
                r = ref_sh(k, dv[j], es[FLAG_C]);
                op(so[k], 3'h0, dv[j]);
                chk("shift result", {rd_we, rd_data}, {1'b1, r[7:0]});
                if (k < 5) es[3:0] = {r[7] ^ r[8], r[7], r[7:0] == 8'h00, r[8]};
                chk("shift flags", status_register, es);
            end
        end
    endtask : t_shift

    task automatic t_flags();
        bfm_op_t st[8] = '{CARRY_SET_OP, ZERO_SET_OP, NEGATIVE_SET_OP, OVERFLOW_SET_OP,
            SIGN_SET_OP, HALF_CARRY_SET_OP, TRANSFER_SET_OP, IRQ_ENABLE_OP};
        bfm_op_t cl[8] = '{CARRY_CLEAR_OP, ZERO_CLEAR_OP, NEGATIVE_CLEAR_OP, OVERFLOW_CLEAR_OP,
            SIGN_CLEAR_OP, HALF_CARRY_CLEAR_OP, TRANSFER_CLEAR_OP, IRQ_DISABLE_OP};
        for (int i = 0; i < 8; i++) begin
            op(st[i], 3'h0, 8'h00);
            es[i] = 1'b1;
            chk("flag set", status_register, es);
            op(FLAG_CLEAR_GENERIC_OP, 3'(i), 8'h00);
            es[i] = 1'b0;
            chk("generic clear", status_register, es);
            op(FLAG_SET_GENERIC_OP, 3'(i), 8'h00);
            es[i] = 1'b1;
            chk("generic set", status_register, es);
            op(cl[i], 3'h0, 8'h00);
            es[i] = 1'b0;
            chk("flag clear", status_register, es);
        end
    endtask : t_flags

    task automatic t_bits();
        op(BIT_TO_TRANSFER_OP, 3'h4, 8'h10);
        es[FLAG_T] = 1'b1;
        chk("store set", status_register, es);
        op(TRANSFER_TO_BIT_OP, 3'h1, 8'hF0);
        chk("load one", {rd_we, rd_data, status_register}, {1'b1, 8'hF2, es});
        op(BIT_TO_TRANSFER_OP, 3'h7, 8'h7F);
        es[FLAG_T] = 1'b0;
        chk("store clear", status_register, es);
        op(TRANSFER_TO_BIT_OP, 3'h7, 8'hFF);
        chk("load zero", {rd_we, rd_data, status_register}, {1'b1, 8'h7F, es});
    endtask : t_bits

    task automatic t_ctrl();
        bfm_op_t co[4] = '{NOP_OP, SLEEP_OP, WATCHDOG_RESTART_OP, BREAK_OP};
        for (int i = 0; i < 4; i++) begin
            op(co[i], 3'h0, 8'hFF);
            chk("control op", {sleep_req, wdt_restart, break_req, rd_we, io_re, op_ready,
                status_register}, {3'(i == 0 ? 0 : 8 >> i), 3'h1, es});
            @(posedge clk);
            #1;
            chk("pulse ends", {sleep_req, wdt_restart, break_req}, 3'h0);
        end
        bus(1'b0, OFS_STATE, 32'h0);
        chk("retired count", rdv, 32'h84);
        bus(1'b1, OFS_CONTROL, 32'h0);
        op(BREAK_OP, 3'h0, 8'hFF);
        chk("break masked", {break_req, op_ready, status_register}, {2'h1, es});
    endtask : t_ctrl

    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_io();
        t_shift();
        t_flags();
        t_bits();
        t_ctrl();
        complete_run();
    end
endmodule : bit_flag_manipulation_unit_tb_top
